// File: hdl/vbi_anc_defs.vh
// vbi_anc_defs.vh: register map, field positions, reset values and packet constants
// assumes: included by the formatter source, 32-bit apb data
`ifndef VBI_ANC_DEFS_VH
`define VBI_ANC_DEFS_VH

// ************************************************************
// register offsets
// ************************************************************
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_LMODE_BASE  12'h040
`define OFS_FIFO_DATA   12'h0B0

// ************************************************************
// control fields and reset value
// ************************************************************
`define CTRL_BT656_BIT  0
`define CTRL_RAW_BIT    1
`define CTRL_SEL_LSB    2
`define CTRL_STD625_BIT 4
`define CTRL_RESET      5'h01
`define SEL_UNSCALED    2'h0
`define SEL_SCALED      2'h1
`define SEL_INTERLEAVE  2'h2

// ************************************************************
// status and fifo data fields
// ************************************************************
`define STAT_PEND_BIT   0
`define STAT_OVF_BIT    1
`define STAT_CNT_LSB    16
`define FIFO_VALID_BIT  8

// ************************************************************
// line timing and vbi line range
// ************************************************************
`define TOTAL_PIX_525   11'd858
`define TOTAL_PIX_625   11'd864
`define ACTIVE_PIX      11'd720
`define VBI_FIRST_LINE  10'd6
`define VBI_LAST_LINE   10'd27
`define LATE_LINE       10'd24
`define VBI_LINES       22
`define LMODE_DEFAULT   4'hF

// ************************************************************
// packet bytes
// ************************************************************
`define ANC_PRE0        8'h00
`define ANC_PRE1        8'hFF
`define ID_FIELD1       8'h91
`define ID_FIELD2       8'h55
`define ID_LATE1        8'h53
`define ID_LATE2        8'h97
`define ANC_FILL        8'h00
`define HDR_BYTES       7'd8
`define LINE_BUF_BYTES  64
`define VBI_FIFO_BYTES  512

`endif

// File: hdl/vbi_ancillary_packet_formatter.v
// vbi_ancillary_packet_formatter.v: sliced vbi packet formatter with apb registers,
// a small input fifo module and the byte fifo that software drains.
// assumes: slicer bytes and video inputs are synchronous to pclk, one output byte per pclk.
`timescale 1ns/1ps
`include "vbi_anc_defs.vh"

// ************************************************************
// small valid/ready fifo
// ************************************************************
module stream_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // fill side
    input  wire             in_valid,
    output reg              in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_reg;
    reg [AW-1:0]    rd_reg;
    reg [AW:0]      cnt_reg;
    wire            push;
    wire            pop;
    wire [AW:0]     cnt_next;

    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data  = mem[rd_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign cnt_next  = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always @(posedge pclk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_reg   <= {AW{1'b0}};
            rd_reg   <= {AW{1'b0}};
            cnt_reg  <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == DEPTH-1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == DEPTH-1) ? {AW{1'b0}} : rd_reg + 1'b1;
            end
            cnt_reg  <= cnt_next;
            in_ready <= (cnt_next < DEPTH);
        end
    end
endmodule // stream_fifo

// ************************************************************
// formatter top
// ************************************************************
module vbi_ancillary_packet_formatter (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // slicer bytes
    input  wire        slc_valid,
    output wire        slc_ready,
    input  wire [7:0]  slc_data,
    input  wire        slc_last,
    input  wire [9:0]  slc_line,
    input  wire        slc_field,
    input  wire        slc_match1,
    input  wire        slc_match2,
    input  wire        slc_error,
    // decoder core video
    input  wire [7:0]  vid_unscaled,
    input  wire [7:0]  vid_scaled,
    input  wire [7:0]  raw_sample,
    input  wire        vblank,
    // output stream
    output reg  [7:0]  vid_out,
    output reg         anc_active,
    output reg         hblank
);
    // ************************************************************
    // registers and state
    // ************************************************************
    localparam ST_IDLE = 1'b0;
    localparam ST_EMIT = 1'b1;

    reg [4:0]  ctrl_reg;
    reg [3:0]  lmode_mem [0:`VBI_LINES-1];
    reg [7:0]  line_buf [0:`LINE_BUF_BYTES-1];
    reg [7:0]  vbi_mem [0:`VBI_FIFO_BYTES-1];
    reg [8:0]  vwr_reg;
    reg [8:0]  vrd_reg;
    reg [9:0]  vcnt_reg;
    reg        ovf_reg;
    reg [9:0]  mline_in_reg;
    reg [3:0]  mflag_in_reg;
    reg [9:0]  pline_reg;
    reg        pfield_reg;
    reg        pm1_reg;
    reg        pm2_reg;
    reg        perr_reg;
    reg [6:0]  cap_reg;
    reg        pend_reg;
    reg        state_reg;
    reg [6:0]  idx_reg;
    reg [7:0]  cs_reg;
    reg [11:0] hcnt_reg;
    reg        phase_reg;

    wire        f_valid;
    wire        f_ready;
    wire [8:0]  f_data;
    wire        cap_take;
    wire [11:0] line_bytes;
    wire [11:0] act_bytes;
    wire        blank_start;
    wire        emit_go;
    wire [5:0]  word_count;
    wire [6:0]  total;
    wire [6:0]  data_end;
    wire        in_vbi;
    wire [3:0]  mode;
    wire [7:0]  pkt_id;
    wire [7:0]  pkt_byte;
    wire        emitting;
    wire        vpush;
    wire        vpop;
    wire        apb_acc;
    wire        apb_wr;
    wire        apb_rd;
    wire        is_lmode;
    wire [11:0] lm_ofs;
    wire [4:0]  lm_idx;
    wire [9:0]  lm_diff;
    reg  [7:0]  hdr_byte;
    reg  [7:0]  sel_byte;

    // parity wrap of a six-bit value
    function [7:0] par6;
        input [5:0] d;
        begin
            par6 = {~(^d), ^d, d};
        end
    endfunction

    // ************************************************************
    // input fifo and capture
    // ************************************************************
    stream_fifo #(.WIDTH(9), .DEPTH(4), .AW(2)) u_in_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (slc_valid),
        .in_ready  (slc_ready),
        .in_data   ({slc_last, slc_data}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // capture stalls while a packet waits for blanking and while it is emitted
    assign f_ready  = ~pend_reg;
    assign cap_take = f_valid & f_ready;

    always @(posedge pclk) begin
        if (cap_take && cap_reg < `LINE_BUF_BYTES) begin
            line_buf[cap_reg[5:0]] <= f_data[7:0];
        end
    end

    // ************************************************************
    // line timing
    // ************************************************************
    assign line_bytes  = {ctrl_reg[`CTRL_STD625_BIT] ? `TOTAL_PIX_625 : `TOTAL_PIX_525, 1'b0};
    assign act_bytes   = {`ACTIVE_PIX, 1'b0};
    assign blank_start = (hcnt_reg == act_bytes - 12'd1);
    assign emit_go     = pend_reg & blank_start & (state_reg == ST_IDLE);

    // ************************************************************
    // packet assembly
    // ************************************************************
    assign word_count = {1'b0, cap_reg[6:2]} + 6'd1;
    assign total    = `HDR_BYTES + {word_count[4:0], 2'b00};
    assign data_end = `HDR_BYTES + cap_reg;
    assign in_vbi   = (pline_reg >= `VBI_FIRST_LINE) && (pline_reg <= `VBI_LAST_LINE);
    assign lm_diff  = pline_reg - `VBI_FIRST_LINE;
    assign lm_idx   = lm_diff[4:0];
    assign mode     = in_vbi ? lmode_mem[lm_idx] : `LMODE_DEFAULT;
    assign pkt_id   = (pline_reg >= `LATE_LINE) ? (pfield_reg ? `ID_LATE2 : `ID_LATE1)
                                               : (pfield_reg ? `ID_FIELD2 : `ID_FIELD1);
    assign emitting = (state_reg == ST_EMIT);

    always @* begin
        case (idx_reg[2:0])
            3'd0:    hdr_byte = `ANC_PRE0;
            3'd1:    hdr_byte = `ANC_PRE1;
            3'd2:    hdr_byte = `ANC_PRE1;
            3'd3:    hdr_byte = pkt_id;
            3'd4:    hdr_byte = par6({2'b00, mode});
            3'd5:    hdr_byte = par6(word_count);
            3'd6:    hdr_byte = pline_reg[7:0];
            3'd7:    hdr_byte = {3'b000, perr_reg, pm1_reg, pm2_reg, pline_reg[9:8]};
            default: hdr_byte = `ANC_FILL;
        endcase
    end

    assign pkt_byte = (idx_reg < `HDR_BYTES) ? hdr_byte :
                      (idx_reg < data_end)   ? line_buf[idx_reg[5:0] - 6'd8] :
                      (idx_reg == data_end)  ? par6(cs_reg[5:0]) : `ANC_FILL;

    // ************************************************************
    // capture, emission and timing state
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_reg      <= 7'd0;
            pend_reg     <= 1'b0;
            state_reg    <= ST_IDLE;
            idx_reg      <= 7'd0;
            cs_reg       <= 8'h00;
            hcnt_reg     <= 12'd0;
            phase_reg    <= 1'b0;
            mline_in_reg <= 10'd0;
            mflag_in_reg <= 4'h0;
            pline_reg    <= 10'd0;
            pfield_reg   <= 1'b0;
            pm1_reg      <= 1'b0;
            pm2_reg      <= 1'b0;
            perr_reg     <= 1'b0;
        end else begin
            hcnt_reg  <= (hcnt_reg >= line_bytes - 12'd1) ? 12'd0 : hcnt_reg + 12'd1;
            phase_reg <= ~phase_reg;
            if (slc_valid && slc_ready && slc_last) begin
                mline_in_reg <= slc_line;
                mflag_in_reg <= {slc_field, slc_match1, slc_match2, slc_error};
            end
            if (cap_take) begin
                if (cap_reg < `LINE_BUF_BYTES) begin
                    cap_reg <= cap_reg + 7'd1;
                end
                if (f_data[8]) begin
                    pend_reg   <= 1'b1;
                    pline_reg  <= mline_in_reg;
                    pfield_reg <= mflag_in_reg[3];
                    pm1_reg    <= mflag_in_reg[2];
                    pm2_reg    <= mflag_in_reg[1];
                    perr_reg   <= mflag_in_reg[0];
                end
            end
            case (state_reg)
                ST_IDLE: begin
                    if (emit_go) begin
                        state_reg <= ST_EMIT;
                        idx_reg   <= 7'd0;
                        cs_reg    <= 8'h00;
                    end
                end
                ST_EMIT: begin
                    if (idx_reg >= 7'd3 && idx_reg < data_end) begin
                        cs_reg <= cs_reg + pkt_byte;
                    end
                    if (idx_reg == total - 7'd1) begin
                        state_reg <= ST_IDLE;
                        pend_reg  <= 1'b0;
                        cap_reg   <= 7'd0;
                    end else begin
                        idx_reg <= idx_reg + 7'd1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // output stream
    // ************************************************************
    always @* begin
        case (ctrl_reg[`CTRL_SEL_LSB+1:`CTRL_SEL_LSB])
            `SEL_UNSCALED:   sel_byte = vid_unscaled;
            `SEL_SCALED:     sel_byte = vid_scaled;
            `SEL_INTERLEAVE: sel_byte = phase_reg ? vid_scaled : vid_unscaled;
            default:         sel_byte = vid_unscaled;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vid_out    <= 8'h00;
            anc_active <= 1'b0;
            hblank     <= 1'b0;
        end else begin
            hblank <= (hcnt_reg >= act_bytes - 12'd1) && (hcnt_reg < line_bytes - 12'd1);
            if (emitting && ctrl_reg[`CTRL_BT656_BIT]) begin
                vid_out    <= pkt_byte;
                anc_active <= 1'b1;
            end else if (ctrl_reg[`CTRL_RAW_BIT] && (vblank || hcnt_reg < act_bytes)) begin
                vid_out    <= raw_sample;
                anc_active <= 1'b1;
            end else begin
                vid_out    <= sel_byte;
                anc_active <= 1'b0;
            end
        end
    end

    // ************************************************************
    // vbi byte fifo
    // ************************************************************
    assign apb_acc  = psel & penable & ~pready;
    assign apb_wr   = apb_acc & pwrite;
    assign apb_rd   = apb_acc & ~pwrite;
    assign vpush    = emitting && (vcnt_reg != `VBI_FIFO_BYTES);
    assign vpop     = apb_rd && (paddr == `OFS_FIFO_DATA) && (vcnt_reg != 10'd0);
    assign lm_ofs   = paddr - `OFS_LMODE_BASE;
    assign is_lmode = (paddr >= `OFS_LMODE_BASE) && (lm_ofs[11:2] < `VBI_LINES) && (paddr[1:0] == 2'b00);

    always @(posedge pclk) begin
        if (vpush) begin
            vbi_mem[vwr_reg] <= pkt_byte;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vwr_reg  <= 9'd0;
            vrd_reg  <= 9'd0;
            vcnt_reg <= 10'd0;
            ovf_reg  <= 1'b0;
        end else begin
            if (vpush) begin
                vwr_reg <= vwr_reg + 9'd1;
            end
            if (vpop) begin
                vrd_reg <= vrd_reg + 9'd1;
            end
            vcnt_reg <= vcnt_reg + {9'd0, vpush} - {9'd0, vpop};
            if (emitting && !vpush) begin
                ovf_reg <= 1'b1;
            end else if (apb_wr && paddr == `OFS_STATUS && pwdata[`STAT_OVF_BIT]) begin
                ovf_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // apb slave
    // ************************************************************
    always @(posedge pclk) begin
        if (apb_wr && is_lmode) begin
            lmode_mem[lm_ofs[6:2]] <= pwdata[3:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `CTRL_RESET;
            prdata   <= 32'h00000000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            pready  <= apb_acc;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            if (apb_wr && paddr == `OFS_CTRL) begin
                ctrl_reg <= pwdata[4:0];
            end
            if (apb_acc) begin
                if (paddr == `OFS_CTRL) begin
                    prdata <= {27'd0, ctrl_reg};
                end else if (paddr == `OFS_STATUS) begin
                    prdata <= {6'd0, vcnt_reg, 14'd0, ovf_reg, pend_reg};
                end else if (paddr == `OFS_FIFO_DATA) begin
                    if (!pwrite) begin
                        prdata <= {23'd0, (vcnt_reg != 10'd0), vbi_mem[vrd_reg]};
                    end
                end else if (is_lmode) begin
                    prdata <= {28'd0, lmode_mem[lm_ofs[6:2]]};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end
endmodule // vbi_ancillary_packet_formatter

// File: tb/tb.sv
// tb.sv: directed bench for the vbi ancillary packet formatter
// assumes: design, checker and sink model compiled first, 200 MHz pclk
`timescale 1ns/1ps
`include "vbi_anc_defs.vh"
module tb;
    logic        pclk, presetn, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, slc_ready, anc_active, hblank, vblank;
    logic        slc_valid, slc_last, slc_field, slc_match1, slc_match2, slc_error;
    logic [7:0]  slc_data, vid_unscaled, vid_scaled, raw_sample, vid_out, a;
    logic [9:0]  slc_line;
    logic [7:0]  exp_q[$];
    int          bad_count, n_compared, lo, tot;

    vbi_ancillary_packet_formatter u_vbi_ancillary_packet_formatter (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slc_valid(slc_valid), .slc_ready(slc_ready), .slc_data(slc_data), .slc_last(slc_last),
        .slc_line(slc_line), .slc_field(slc_field), .slc_match1(slc_match1),
        .slc_match2(slc_match2), .slc_error(slc_error), .vid_unscaled(vid_unscaled),
        .vid_scaled(vid_scaled), .raw_sample(raw_sample), .vblank(vblank),
        .vid_out(vid_out), .anc_active(anc_active), .hblank(hblank));
    video_sink_model u_video_sink_model (.pclk(pclk), .vid_out(vid_out), .anc_active(anc_active));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ************************************************************
    // access tasks
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) bad_count++;
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_lvl(input logic v);
        int k;
        k = 0;
        while (hblank !== v && k < 4000) begin
            @(posedge pclk);
            k++;
        end
        if (hblank !== v) bad_count++;
    endtask
    function automatic logic [7:0] par(input logic [5:0] v);
        return {~^v, ^v, v};
    endfunction

    // one sliced line: slicer bytes in, packet on stream and in fifo out
    task automatic one_line(input logic f, input logic [9:0] ln, input logic [3:0] md,
                            input logic [2:0] fl, input int n);
        int         k;
        int         word_count;
        logic [7:0] cs;
        logic       inr;
        inr = ln >= `VBI_FIRST_LINE && ln <= `VBI_LAST_LINE;
        word_count = (n + 4) / 4;
        if (inr)
            apb(1'b1, `OFS_LMODE_BASE + 12'(4 * (ln - `VBI_FIRST_LINE)), {28'h0, md});
        exp_q = {8'h00, 8'hFF, 8'hFF};
        exp_q.push_back(ln >= `LATE_LINE ? (f ? `ID_LATE2 : `ID_LATE1) : (f ? `ID_FIELD2 : `ID_FIELD1));
        exp_q.push_back(par({2'b00, inr ? md : 4'hF}));
        exp_q.push_back(par(word_count[5:0]));
        exp_q.push_back(ln[7:0]);
        exp_q.push_back({3'b000, fl, ln[9:8]});
        for (int i = 0; i < n; i++)
            exp_q.push_back(8'h40 + i[7:0]);
        cs = 8'h00;
        for (int i = 3; i < exp_q.size(); i++)
            cs = cs + exp_q[i];
        exp_q.push_back(par(cs[5:0]));
        while (exp_q.size() < 8 + 4 * word_count)
            exp_q.push_back(`ANC_FILL);
        slc_field <= f;
        slc_line  <= ln;
        {slc_error, slc_match1, slc_match2} <= fl;
        u_video_sink_model.pkt.delete();
        for (int i = 0; i < n; i++) begin
            slc_valid <= 1'b1;
            slc_data  <= 8'h40 + i[7:0];
            slc_last  <= (i == n - 1);
            k = 0;
            do begin
                @(posedge pclk);
                k++;
            end while (slc_ready !== 1'b1 && k < 4000);
        end
        slc_valid <= 1'b0;
        slc_last  <= 1'b0;
        k = 0;
        while (u_video_sink_model.pkt.size() < exp_q.size() && k < 6000) begin
            @(posedge pclk);
            k++;
        end
        repeat (2) @(posedge pclk);
        chk(k < 3456, 1);
        chk(u_video_sink_model.pkt.size(), exp_q.size());
        foreach (exp_q[i])
            chk(u_video_sink_model.pkt[i], exp_q[i]);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rd[25:16], exp_q.size());
        chk(rd[1:0], 2'b00);
        foreach (exp_q[i]) begin
            apb(1'b0, `OFS_FIFO_DATA, 32'h0);
            chk(rd[8:0], {1'b1, exp_q[i]});
        end
        apb(1'b0, `OFS_FIFO_DATA, 32'h0);
        chk(rd[8], 1'b0);
    endtask

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        {psel, penable, pwrite, paddr, pwdata, vblank} = '0;
        {slc_valid, slc_last, slc_field, slc_match1, slc_match2, slc_error} = '0;
        slc_data     = 8'h00;
        slc_line     = 10'h000;
        vid_unscaled = 8'h3C;
        vid_scaled   = 8'hC3;
        raw_sample   = 8'hA5;
        presetn      = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk(rd, `CTRL_RESET);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        one_line(1'b0, 10'd10, 4'h4, 3'b101, 4);
        one_line(1'b1, 10'd12, 4'h7, 3'b010, 7);
        one_line(1'b0, 10'd24, 4'h0, 3'b011, 5);
        one_line(1'b1, 10'd27, 4'h9, 3'b100, 8);
        one_line(1'b1, 10'd300, 4'h2, 3'b111, 6);
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, `OFS_CTRL, {27'h0, s[0], 4'h1});
            wait_lvl(1'b1);
            wait_lvl(1'b0);
            lo = 0;
            while (hblank === 1'b0 && lo < 4000) begin
                @(posedge pclk);
                lo++;
            end
            tot = lo;
            while (hblank === 1'b1 && tot < 8000) begin
                @(posedge pclk);
                tot++;
            end
            chk(lo, 2 * `ACTIVE_PIX);
            chk(tot, s ? 2 * `TOTAL_PIX_625 : 2 * `TOTAL_PIX_525);
        end
        for (int s = 0; s < 3; s++) begin
            apb(1'b1, `OFS_CTRL, {28'h0, s[1:0], 2'b01});
            wait_lvl(1'b1);
            wait_lvl(1'b0);
            repeat (4) @(posedge pclk);
            a = vid_out;
            @(posedge pclk);
            if (s < 2)
                chk(vid_out, s ? vid_scaled : vid_unscaled);
            else
                chk(a ^ vid_out, vid_scaled ^ vid_unscaled);
        end
        apb(1'b1, `OFS_CTRL, 32'h3);
        vblank <= 1'b1;
        wait_lvl(1'b1);
        repeat (4) @(posedge pclk);
        chk({anc_active, vid_out}, {1'b1, raw_sample});
        vblank <= 1'b0;
        wait_lvl(1'b0);
        repeat (4) @(posedge pclk);
        chk({anc_active, vid_out}, {1'b1, raw_sample});
        close_out();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        bad_count++;
        close_out();
    end
endmodule // tb

// File: tb/vbi_anc_properties.sv
// vbi_anc_properties.sv: port checks for the packet formatter
// assumes: bound to the formatter top, single pclk domain
`timescale 1ns/1ps
module vbi_anc_properties (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // stream
    input wire logic [7:0]  vid_out,
    input wire logic        anc_active
);
    logic       raw_q;
    logic [7:0] cnt;
    logic [5:0] words_q;
    logic       pkt;
    assign pkt = anc_active && !raw_q;
    // raw mode shadow and packet byte index
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_q <= 1'b0;
            cnt   <= 8'h00;
            words_q <= 6'h00;
        end else begin
            if (psel && penable && pwrite && !pready && paddr == 12'h000)
                raw_q <= pwdata[1];
            cnt <= anc_active ? cnt + 8'h01 : 8'h00;
            if (pkt && cnt == 8'h05)
                words_q <= vid_out[5:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready too long");
    a_slverr_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error reply");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside reply");
    a_preamble_bytes: assert property ($rose(anc_active) && !raw_q |->
        vid_out == 8'h00 ##1 vid_out == 8'hFF ##1 vid_out == 8'hFF)
        else $error("bad preamble");
    a_id_format: assert property (pkt && cnt == 8'h03 |-> vid_out[5:3] == 3'b010 &&
        vid_out[6] == ^vid_out[5:0] && vid_out[7] == !vid_out[6])
        else $error("bad packet id");
    a_hdr_parity: assert property (pkt && (cnt == 8'h04 || cnt == 8'h05) |->
        vid_out[6] == ^vid_out[5:0] && vid_out[7] != vid_out[6])
        else $error("bad header parity");
    a_byte7_zero: assert property (pkt && cnt == 8'h07 |-> vid_out[7:5] == 3'b000)
        else $error("flag byte top bits set");
    a_pkt_length: assert property ($fell(anc_active) && !raw_q |->
        cnt == 8'd8 + {words_q, 2'b00})
        else $error("packet length wrong");
    c_packet: cover property ($fell(anc_active) && !raw_q);
    c_slverr: cover property (pslverr);
    c_raw: cover property (raw_q && anc_active);
endmodule // vbi_anc_properties

bind vbi_ancillary_packet_formatter vbi_anc_properties u_vbi_anc_properties (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vid_out(vid_out), .anc_active(anc_active));

// File: tb/video_sink_model.sv
// video_sink_model.sv: downstream receiver that keeps every flagged stream byte
// assumes: one byte per pclk on vid_out while anc_active is high
`timescale 1ns/1ps
module video_sink_model (
    // clock
    input wire logic       pclk,
    // stream
    input wire logic [7:0] vid_out,
    input wire logic       anc_active
);
    logic [7:0] pkt[$];
    // receiver has no flow control, it takes each byte as it comes
    always @(posedge pclk) begin
        if (anc_active === 1'b1)
            pkt.push_back(vid_out);
    end
endmodule // video_sink_model
